// ===== design/modem_config_register_bank.sv
// Modem configuration register bank with serial register access
`timescale 1ns/10ps
`include "modem_cfg_consts.svh"
module modem_config_register_bank #(
  parameter int SLOW_DIV = `SLOW_RISE_DIV
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_high_band,
  input wire logic i_low_power,
  input wire logic i_preamble_det,
  input wire logic [9:0] i_afc_result,
  input wire logic i_gain_inc_req,
  input wire logic i_gain_dec_req,
  input wire logic i_lna_gain_high,
  input wire logic [7:0] i_rssi,
  output logic o_agc_hold,
  output logic o_gain_inc,
  output logic o_gain_dec,
  output logic [3:0] o_lna_gain_comp,
  output logic [7:0] o_rssi_smoothed,
  output logic [1:0] o_pga_window_ref,
  output logic [7:0] o_data_rate_low,
  output logic o_ph_pwdn,
  output logic o_tx_preamble_bit,
  output logic o_manch_invert,
  output logic o_manch_enable,
  output logic o_whiten_enable,
  output logic [8:0] o_deviation_setting,
  output logic [18:0] o_deviation_hz,
  output logic [9:0] o_offset_setting,
  output logic signed [24:0] o_offset_chz
);
  reg_access_if bus ();

  logic [7:0] agc_override_two_q;
  logic [7:0] data_rate_low_byte_q;
  logic [7:0] modulation_control_one_q;
  logic [7:0] modulation_control_two_q;
  logic [7:0] deviation_low_q;
  logic [9:0] offset_setting_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [$clog2(SLOW_DIV+1)-1:0] slow_cnt_q;
  logic [8:0] deviation_setting;
  logic [8:0] rssi_sum;
  logic signed [25:0] ofs_step;
  logic signed [25:0] ofs_scaled;
  logic agc_slow;

  // Host access only through the serial port
  spi_reg_port u_port (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_sel_n(i_sel_n),
    .i_sclk(i_sclk),
    .i_sdi(i_sdi),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe),
    .bus(bus)
  );

  // Register writes; unmapped addresses are ignored
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      agc_override_two_q <= `RST_AGC_OVR_TWO;
      data_rate_low_byte_q <= `RST_DATA_RATE_LO;
      modulation_control_one_q <= `RST_MOD_CTRL_ONE;
      modulation_control_two_q <= `RST_MOD_CTRL_TWO;
      deviation_low_q <= `RST_DEV_LOW;
      offset_setting_q <= `RST_OFS;
    end
    else if (bus.wr_stb)
    begin
      unique case (bus.addr)
        `ADDR_AGC_OVR_TWO: agc_override_two_q <= bus.wdata;
        `ADDR_DATA_RATE_LO: data_rate_low_byte_q <= bus.wdata;
        `ADDR_MOD_CTRL_ONE: modulation_control_one_q <= bus.wdata & `MASK_MOD_CTRL_ONE;
        `ADDR_MOD_CTRL_TWO: modulation_control_two_q <= bus.wdata;
        `ADDR_DEV_LOW: deviation_low_q <= bus.wdata;
        `ADDR_OFS_LOW: offset_setting_q[7:0] <= bus.wdata;
        `ADDR_OFS_HIGH: offset_setting_q[9:8] <= bus.wdata[1:0];
        default:
        begin
        end
      endcase
    end
  end

  // Read mux; offset reads show the AFC result, not the written setting
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (bus.addr)
      `ADDR_AGC_OVR_TWO: rdata_d = agc_override_two_q;
      `ADDR_DATA_RATE_LO: rdata_d = data_rate_low_byte_q;
      `ADDR_MOD_CTRL_ONE: rdata_d = modulation_control_one_q;
      `ADDR_MOD_CTRL_TWO: rdata_d = modulation_control_two_q;
      `ADDR_DEV_LOW: rdata_d = deviation_low_q;
      `ADDR_OFS_LOW: rdata_d = i_afc_result[7:0];
      `ADDR_OFS_HIGH: rdata_d = {6'h00, i_afc_result[9:8]};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (bus.rd_stb)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign bus.rdata = rdata_q;

  // Gain loop steering
  assign agc_slow = agc_override_two_q[`BIT_AGC_SLOW];

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_agc_hold <= 1'b0;
      o_gain_dec <= 1'b0;
    end
    else
    begin
      o_agc_hold <= i_preamble_det & ~agc_override_two_q[`BIT_AGC_IGN_PRE];
      o_gain_dec <= i_gain_dec_req;
    end
  end

  // Slow rise passes one increase request in SLOW_DIV
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      slow_cnt_q <= '0;
      o_gain_inc <= 1'b0;
    end
    else
    begin
      o_gain_inc <= 1'b0;
      if (i_gain_inc_req)
      begin
        if (!agc_slow || slow_cnt_q == ($bits(slow_cnt_q))'(SLOW_DIV - 1))
        begin
          o_gain_inc <= 1'b1;
          slow_cnt_q <= '0;
        end
        else
        begin
          slow_cnt_q <= slow_cnt_q + 1'b1;
        end
      end
    end
  end

  // RSSI lifted by the compensation while the LNA sits at low gain
  assign rssi_sum = {1'b0, i_rssi} + {5'h00, o_lna_gain_comp};

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_lna_gain_comp <= 4'h0;
      o_rssi_smoothed <= 8'h00;
      o_pga_window_ref <= 2'h0;
    end
    else
    begin
      o_lna_gain_comp <= agc_override_two_q[`LNA_COMP_HI:`LNA_COMP_LO];
      if (i_lna_gain_high)
      begin
        o_rssi_smoothed <= i_rssi;
      end
      else
      begin
        o_rssi_smoothed <= rssi_sum[8] ? 8'hFF : rssi_sum[7:0];
      end
      o_pga_window_ref <= agc_override_two_q[`PGA_REF_HI:`PGA_REF_LO];
    end
  end

  // Modulation mode controls
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_data_rate_low <= `RST_DATA_RATE_LO;
      o_ph_pwdn <= 1'b0;
      o_tx_preamble_bit <= 1'b0;
      o_manch_invert <= 1'b0;
      o_manch_enable <= 1'b0;
      o_whiten_enable <= 1'b0;
    end
    else
    begin
      o_data_rate_low <= data_rate_low_byte_q;
      o_ph_pwdn <= i_low_power & modulation_control_one_q[`BIT_PH_PWDN];
      // Transmit preamble level only; receive path never sees it
      o_tx_preamble_bit <= modulation_control_one_q[`BIT_MAN_EN]
                           & modulation_control_one_q[`BIT_MAN_PPOL];
      o_manch_invert <= modulation_control_one_q[`BIT_MAN_INV];
      o_manch_enable <= modulation_control_one_q[`BIT_MAN_EN];
      o_whiten_enable <= modulation_control_one_q[`BIT_WHITEN];
    end
  end

  // Deviation and offset scaling
  assign deviation_setting = {modulation_control_two_q[`BIT_DEV_MSB], deviation_low_q};
  assign ofs_step = 26'(i_high_band ? 2 * `OFS_STEP_CHZ : `OFS_STEP_CHZ);
  assign ofs_scaled = 26'($signed(offset_setting_q) * ofs_step);

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_deviation_setting <= 9'h000;
      o_deviation_hz <= 19'h00000;
      o_offset_setting <= `RST_OFS;
      o_offset_chz <= 25'sh0000000;
    end
    else
    begin
      o_deviation_setting <= deviation_setting;
      o_deviation_hz <= 19'(deviation_setting * `DEV_STEP_HZ);
      o_offset_setting <= offset_setting_q;
      o_offset_chz <= ofs_scaled[24:0];
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_wr_ign_set;
    bus.wr_stb && bus.addr == `ADDR_AGC_OVR_TWO && bus.wdata[`BIT_AGC_IGN_PRE];
  endsequence

  sequence s_rd_ofs_low;
    bus.rd_stb && bus.addr == `ADDR_OFS_LOW;
  endsequence

  sequence s_rd_ofs_high;
    bus.rd_stb && bus.addr == `ADDR_OFS_HIGH;
  endsequence

  a_agc_ignore_pre:
    assert property (s_wr_ign_set ##1 !bus.wr_stb |=> !o_agc_hold)
    else $error("AGC held by preamble while ignore bit set");

  a_gain_dec_pass:
    assert property (i_gain_dec_req |=> o_gain_dec)
    else $error("gain decrease slowed");

  a_slow_rise_gap:
    assert property (agc_slow && o_gain_inc && $stable(agc_override_two_q) |-> !$past(o_gain_inc))
    else $error("slow rise passed back to back increases");

  a_lna_comp_add:
    assert property (!i_lna_gain_high && !rssi_sum[8] |=> o_rssi_smoothed == $past(rssi_sum[7:0]))
    else $error("RSSI compensation not applied");

  a_pga_ref_wr:
    assert property (bus.wr_stb && bus.addr == `ADDR_AGC_OVR_TWO ##1 !bus.wr_stb
                     |=> o_pga_window_ref == $past(bus.wdata[1:0], 2))
    else $error("PGA reference not taken from write");

  a_reset_values:
    assert property ($past(i_sys_rst) |-> data_rate_low_byte_q == `RST_DATA_RATE_LO
                     && deviation_low_q == `RST_DEV_LOW)
    else $error("wrong reset value");

  a_ph_pwdn_gate:
    assert property (o_ph_pwdn |-> $past(i_low_power))
    else $error("packet handler down outside low power");

  a_preamble_manch:
    assert property (o_tx_preamble_bit |-> o_manch_enable)
    else $error("preamble polarity active without Manchester");

  a_dev_scale:
    assert property (o_deviation_hz == 19'(o_deviation_setting * `DEV_STEP_HZ))
    else $error("deviation scaling wrong");

  a_ofs_sign:
    assert property (o_offset_setting[9] |-> o_offset_chz < 0)
    else $error("negative offset not signed");

  a_ofs_rd_afc:
    assert property (s_rd_ofs_low |=> rdata_q == $past(i_afc_result[7:0]))
    else $error("offset read not AFC result");

  a_ofs_high_rsvd:
    assert property (s_rd_ofs_high |=> rdata_q[7:2] == 6'h00)
    else $error("reserved offset bits not zero");

  a_ofs_kept:
    assert property (s_rd_ofs_low ##1 !bus.wr_stb |-> $stable(offset_setting_q))
    else $error("offset setting disturbed by read");
endmodule : modem_config_register_bank

// ===== design/spi_reg_port.sv
// Serial register port: oversampled slave, one address byte then one data byte
`timescale 1ns/10ps
module spi_reg_port (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  reg_access_if.engine bus
);
  logic [1:0] sel_sync_q;
  logic [2:0] sclk_sync_q;
  logic [1:0] sdi_sync_q;
  modem_cfg_pkg::spi_phase_t phase_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic load_q;
  logic wr_dir_q;
  logic sel_act;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] byte_in;

  assign sel_act = ~sel_sync_q[1];
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign byte_in = {shift_q[6:0], sdi_sync_q[1]};

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sel_sync_q <= 2'h3;
      sclk_sync_q <= 3'h0;
      sdi_sync_q <= 2'h0;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[0], i_sel_n};
      sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
      sdi_sync_q <= {sdi_sync_q[0], i_sdi};
    end
  end

  // Frame sequencing; bits past the data byte are ignored
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      phase_q <= modem_cfg_pkg::PH_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
    end
    else if (!sel_act)
    begin
      phase_q <= modem_cfg_pkg::PH_IDLE;
      bit_cnt_q <= 3'h0;
    end
    else if (sclk_rise && phase_q != modem_cfg_pkg::PH_DONE)
    begin
      shift_q <= byte_in;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7)
      begin
        phase_q <= (phase_q == modem_cfg_pkg::PH_DATA) ? modem_cfg_pkg::PH_DONE
                                                      : modem_cfg_pkg::PH_DATA;
      end
    end
    else if (phase_q == modem_cfg_pkg::PH_IDLE)
    begin
      phase_q <= modem_cfg_pkg::PH_ADDR;
    end
  end

  // Address, direction and strobes toward the register file
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      bus.rd_stb <= 1'b0;
      bus.wr_stb <= 1'b0;
      bus.addr <= 7'h00;
      bus.wdata <= 8'h00;
      wr_dir_q <= 1'b0;
    end
    else
    begin
      bus.rd_stb <= 1'b0;
      bus.wr_stb <= 1'b0;
      if (sel_act && sclk_rise && bit_cnt_q == 3'h7)
      begin
        if (phase_q == modem_cfg_pkg::PH_ADDR)
        begin
          bus.addr <= byte_in[6:0];
          bus.rd_stb <= ~byte_in[7];
          wr_dir_q <= byte_in[7];
        end
        else if (phase_q == modem_cfg_pkg::PH_DATA && wr_dir_q)
        begin
          bus.wdata <= byte_in;
          bus.wr_stb <= 1'b1;
        end
      end
    end
  end

  // Read data leaves MSB first, each bit set up on a falling clock
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      load_q <= 1'b0;
      tx_q <= 8'h00;
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
    end
    else
    begin
      load_q <= bus.rd_stb;
      o_sdo_oe <= sel_act;
      if (load_q)
      begin
        tx_q <= bus.rdata;
      end
      else if (sclk_fall && phase_q == modem_cfg_pkg::PH_DATA)
      begin
        o_sdo <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
endmodule : spi_reg_port

// ===== pkg/modem_cfg_consts.svh
// Register offsets, field positions, reset values and scale factors
`ifndef MODEM_CFG_CONSTS_SVH
`define MODEM_CFG_CONSTS_SVH
`define ADDR_AGC_OVR_TWO 7'h6A
`define ADDR_DATA_RATE_LO 7'h6F
`define ADDR_MOD_CTRL_ONE 7'h70
`define ADDR_MOD_CTRL_TWO 7'h71
`define ADDR_DEV_LOW 7'h72
`define ADDR_OFS_LOW 7'h73
`define ADDR_OFS_HIGH 7'h74
`define RST_AGC_OVR_TWO 8'h00
`define RST_DATA_RATE_LO 8'h3D
`define RST_MOD_CTRL_ONE 8'h00
`define RST_MOD_CTRL_TWO 8'h00
`define RST_DEV_LOW 8'h20
`define RST_OFS 10'h000
`define MASK_MOD_CTRL_ONE 8'h3F
`define BIT_AGC_IGN_PRE 7
`define BIT_AGC_SLOW 6
`define LNA_COMP_HI 5
`define LNA_COMP_LO 2
`define PGA_REF_HI 1
`define PGA_REF_LO 0
`define BIT_PH_PWDN 4
`define BIT_MAN_PPOL 3
`define BIT_MAN_INV 2
`define BIT_MAN_EN 1
`define BIT_WHITEN 0
`define BIT_DEV_MSB 2
`define DEV_STEP_HZ 625
`define OFS_STEP_CHZ 15625
`define SLOW_RISE_DIV 4
`endif

// ===== pkg/modem_cfg_pkg.sv
// Shared types of the modem configuration bank
package modem_cfg_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_DONE} spi_phase_t;
endpackage : modem_cfg_pkg

// ===== pkg/reg_access_if.sv
// Register access strobes between the serial port and the register file
`timescale 1ns/10ps
interface reg_access_if;
  logic wr_stb;
  logic rd_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport engine (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : reg_access_if

// ===== tb/modem_config_register_bank_tb.sv
// Self-checking bench of the modem configuration register bank
`timescale 1ns/10ps
`include "modem_cfg_consts.svh"
module modem_config_register_bank_tb;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_sel_n, i_sclk, i_sdi, o_sdo, o_sdo_oe;
  logic i_high_band = 1'b0;
  logic i_low_power = 1'b0;
  logic i_preamble_det = 1'b0;
  logic [9:0] i_afc_result = 10'h000;
  logic i_gain_inc_req = 1'b0;
  logic i_gain_dec_req = 1'b0;
  logic i_lna_gain_high = 1'b0;
  logic [7:0] i_rssi = 8'h00;
  logic o_agc_hold, o_gain_inc, o_gain_dec, o_ph_pwdn, o_tx_preamble_bit;
  logic o_manch_invert, o_manch_enable, o_whiten_enable;
  logic [3:0] o_lna_gain_comp;
  logic [7:0] o_rssi_smoothed, o_data_rate_low;
  logic [1:0] o_pga_window_ref;
  logic [8:0] o_deviation_setting;
  logic [18:0] o_deviation_hz;
  logic [9:0] o_offset_setting;
  logic signed [24:0] o_offset_chz;
  int error_cnt = 0;
  int n_checks = 0;
  int inc_cnt = 0;
  logic [7:0] d;
  logic [6:0] ta [5] = '{`ADDR_AGC_OVR_TWO, `ADDR_DATA_RATE_LO, `ADDR_MOD_CTRL_ONE,
    `ADDR_MOD_CTRL_TWO, `ADDR_DEV_LOW};
  logic [7:0] tr [5] = '{8'h00, 8'h3D, 8'h00, 8'h00, 8'h20};
  logic [7:0] tm [5] = '{8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};

  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
    if (o_gain_inc === 1'b1)
      inc_cnt <= inc_cnt + 1;

  spi_host_model spi_host_model_i (.i_mclk, .i_sdo(o_sdo), .o_sel_n(i_sel_n),
    .o_sclk(i_sclk), .o_sdi(i_sdi));
  modem_config_register_bank #(.SLOW_DIV(4)) modem_config_register_bank_i (.i_mclk,
    .i_sys_rst, .i_sel_n, .i_sclk, .i_sdi, .o_sdo, .o_sdo_oe, .i_high_band, .i_low_power,
    .i_preamble_det, .i_afc_result, .i_gain_inc_req, .i_gain_dec_req, .i_lna_gain_high,
    .i_rssi, .o_agc_hold, .o_gain_inc, .o_gain_dec, .o_lna_gain_comp, .o_rssi_smoothed,
    .o_pga_window_ref, .o_data_rate_low, .o_ph_pwdn, .o_tx_preamble_bit, .o_manch_invert,
    .o_manch_enable, .o_whiten_enable, .o_deviation_setting, .o_deviation_hz,
    .o_offset_setting, .o_offset_chz);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] x;
    spi_host_model_i.xfer({1'b1, a}, v, x);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    spi_host_model_i.xfer({1'b0, a}, 8'h00, d);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  // Single-cycle increase requests, counted at the output
  task automatic gain_burst(input int n, input int exp);
    int c0;
    c0 = inc_cnt;
    repeat (n)
    begin
      i_gain_inc_req = 1'b1;
      cyc(1);
      i_gain_inc_req = 1'b0;
      cyc(2);
    end
    cyc(2);
    chk(inc_cnt - c0, exp);
  endtask : gain_burst
  task automatic end_of_test();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (40000) @(posedge i_mclk);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    cyc(4);
    chk(o_data_rate_low, 8'h3D);
    i_sys_rst = 1'b0;
    cyc(3);
    chk(o_deviation_setting, 9'h020);
    chk(o_deviation_hz, 32'd20000);
    for (int i = 0; i < 5; i++)
    begin
      rd(ta[i]);
      chk(d, tr[i]);
      wr(ta[i], 8'hFF);
      rd(ta[i]);
      chk(d, tm[i]);
      wr(ta[i], 8'h5A);
      rd(ta[i]);
      chk(d, 8'h5A & tm[i]);
    end
    // Output enable follows select during a frame
    fork
      rd(`ADDR_DATA_RATE_LO);
      begin
        cyc(40);
        chk(o_sdo_oe, 1'b1);
      end
    join
    chk(o_sdo_oe, 1'b0);
    chk(d, 8'h5A);
    chk(o_data_rate_low, 8'h5A);
    // Compensation 0xD, comparator reference 2, preamble and slow bits clear
    wr(`ADDR_AGC_OVR_TWO, 8'h36);
    chk(o_lna_gain_comp, 4'hD);
    chk(o_pga_window_ref, 2'h2);
    i_rssi = 8'hF8;
    i_preamble_det = 1'b1;
    cyc(2);
    chk(o_rssi_smoothed, 8'hFF);
    chk(o_agc_hold, 1'b1);
    i_rssi = 8'h10;
    cyc(2);
    chk(o_rssi_smoothed, 8'h1D);
    i_lna_gain_high = 1'b1;
    cyc(2);
    chk(o_rssi_smoothed, 8'h10);
    gain_burst(8, 8);
    wr(`ADDR_AGC_OVR_TWO, 8'hF6);
    chk(o_agc_hold, 1'b0);
    gain_burst(8, 2);
    i_gain_dec_req = 1'b1;
    cyc(1);
    chk(o_gain_dec, 1'b1);
    i_gain_dec_req = 1'b0;
    cyc(1);
    chk(o_gain_dec, 1'b0);
    wr(`ADDR_MOD_CTRL_ONE, 8'h1F);
    chk(o_ph_pwdn, 1'b0);
    i_low_power = 1'b1;
    cyc(2);
    chk(o_ph_pwdn, 1'b1);
    chk(o_tx_preamble_bit, 1'b1);
    chk({o_manch_invert, o_manch_enable, o_whiten_enable}, 3'h7);
    // Polarity set with Manchester off: no preamble ones
    wr(`ADDR_MOD_CTRL_ONE, 8'h0D);
    chk(o_tx_preamble_bit, 1'b0);
    chk({o_manch_invert, o_manch_enable, o_whiten_enable}, 3'h5);
    chk(o_ph_pwdn, 1'b0);
    wr(`ADDR_MOD_CTRL_ONE, 8'h02);
    chk(o_tx_preamble_bit, 1'b0);
    chk({o_manch_invert, o_manch_enable, o_whiten_enable}, 3'h2);
    wr(`ADDR_MOD_CTRL_TWO, 8'h04);
    wr(`ADDR_DEV_LOW, 8'h55);
    chk(o_deviation_setting, 9'h155);
    chk(o_deviation_hz, 32'd213125);
    wr(`ADDR_OFS_LOW, 8'hF0);
    wr(`ADDR_OFS_HIGH, 8'hFF);
    chk(o_offset_setting, 10'h3F0);
    i_high_band = 1'b1;
    cyc(2);
    chk(o_offset_chz, -32'sd500000);
    i_high_band = 1'b0;
    cyc(2);
    chk(o_offset_chz, -32'sd250000);
    i_afc_result = 10'h2A5;
    rd(`ADDR_OFS_LOW);
    chk(d, 8'hA5);
    rd(`ADDR_OFS_HIGH);
    chk(d, 8'h02);
    chk(o_offset_setting, 10'h3F0);
    wr(7'h10, 8'hAA);
    rd(7'h10);
    chk(d, 8'h00);
    i_sys_rst = 1'b1;
    cyc(2);
    i_sys_rst = 1'b0;
    cyc(3);
    rd(`ADDR_DEV_LOW);
    chk(d, 8'h20);
    chk(o_offset_setting, 10'h000);
    end_of_test();
  end
endmodule : modem_config_register_bank_tb

// ===== tb/spi_host_model.sv
// Host side of the serial register port
`timescale 1ns/10ps
module spi_host_model (
  input wire logic i_mclk,
  input wire logic i_sdo,
  output logic o_sel_n,
  output logic o_sclk,
  output logic o_sdi
);
  initial
  begin
    o_sel_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : wait_cyc
  // One frame, command byte then data byte, MSB first; clock idles low
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge i_mclk);
    o_sel_n = 1'b0;
    wait_cyc(8);
    for (int i = 15; i >= 0; i--)
    begin
      // Read data byte: line toggles, it carries nothing
      o_sdi = (cmd[7] || i > 7) ? sh[i] : ~o_sdi;
      wait_cyc(10);
      if (i < 8)
        rd[i] = i_sdo;
      o_sclk = 1'b1;
      wait_cyc(10);
      o_sclk = 1'b0;
    end
    wait_cyc(10);
    o_sel_n = 1'b1;
    o_sdi = ~o_sdi;
    wait_cyc(6);
  endtask : xfer
endmodule : spi_host_model
